// ===== lpm_pkg.sv
// lpm_pkg: shared constants and carrier types for the line port loop and monitor block
// assumes a single 250 MHz clock domain and per-channel command bits from the controller
package lpm_pkg;

   // channel count and frame figures
   localparam int          LPM_CHANNELS      = 8;      // channels per port
   localparam int          LPM_MF_FRAMES     = 20;     // line frames per multiframe
   localparam int          LPM_MF_LINK       = 40;     // link frames per multiframe marker
   localparam int          LPM_FRAME_W       = 5;      // width of frame counter

   // reset timing
   localparam int          LPM_CLK_MHZ       = 250;    // clock rate in MHz
   localparam int          LPM_RST_MIN_NS    = 1000;   // least reset pulse, ns
   localparam int          LPM_RST_MIN_CYC   = (LPM_RST_MIN_NS * LPM_CLK_MHZ + 999) / 1000;

   // version answer, value arbitrary
   localparam logic [7:0]  LPM_VERSION       = 8'h21;

   // channel line modes
   typedef enum logic [1:0] {
      LPM_MODE_TRUNK    = 2'h0,
      LPM_MODE_TERM     = 2'h1,
      LPM_MODE_TWO_WIRE = 2'h2
   } lpm_mode_t;

   // per-channel command bits from the controller
   typedef struct packed {
      lpm_mode_t mode;          // line mode of the channel
      logic      loop_bit;      // close analog loop
      logic      external_loop_bit; // external analog loop
      logic      line_out_en;   // transparent output onto line
   } lpm_chan_cmd_t;

   // per-channel analog loop controls
   typedef struct packed {
      logic loop_transp;        // transparent loop, forward path on
      logic loop_block;         // loop with forward path blocked
      logic loop_ext;           // external transparent loop
      logic line_drive;         // drive line output
   } lpm_loop_ctl_t;

   // default loop control after reset
   localparam lpm_loop_ctl_t LPM_LOOP_RST = '0;

endpackage : lpm_pkg

// ===== lpm_cv_chan.sv
// lpm_cv_chan: per-channel code violation check over one multiframe
// assumes violation pulses and frame-bit qualifier come from the line receiver, same clock
`timescale 1ns/1ns
module lpm_cv_chan (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // line events
   input  wire logic two_wire,    // channel in two-wire mode
   input  wire logic viol,        // code violation seen, one-cycle pulse
   input  wire logic frame_pos,   // violation at framing or multiframe bit position
   input  wire logic mf_end,      // multiframe boundary pulse
   // status
   output logic      code_violation_flag
);
   import lpm_pkg::*;

   logic seen_q;                  // violation collected in current multiframe
   logic flag_q;                  // reported flag for the last multiframe
   logic hit;                     // qualified violation

   // framing positions are exempt only on two-wire lines
   assign hit = viol && !(two_wire && frame_pos); // [R11]

   // collect violations; a hit on the boundary starts the next interval
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seen_q <= 1'b0;
      end else if (mf_end) begin
         seen_q <= hit;
      end else if (hit) begin
         seen_q <= 1'b1;
      end
   end

   // evaluate once per multiframe, hold for a whole interval
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (mf_end) begin
         flag_q <= seen_q; // [R12] [R14]
      end
   end

   assign code_violation_flag = flag_q;

endmodule : lpm_cv_chan

// ===== lpm_line_port.sv
// lpm_line_port: loop control, version answer and code violation monitor of a line port
// assumes controller command bits are synchronous to clk; line pins are synchronised here
`timescale 1ns/1ns

// Summary of operation
// [R1] hold reset at least one microsecond
// [R2] reset from processor or delayed reset
// [R3] controller follows fixed initialization order
// [R4] version value returned through command register
// [R5] three analog loops without external parts
// [R6] loop commands only through trunk side
// [R7] controller sets loop and external bits
// [R8] transparent output when line enable set
// [R9] external loop follows external loop bit
// [R10] two-wire loop needs line enable set
// [R11] report violations, two-wire framing bits exempt
// [R12] check once per twenty-frame multiframe
// [R13] controller marks multiframe every fortieth frame
// [R14] flag held per channel one interval
module lpm_line_port #(
   parameter int CHANNELS = lpm_pkg::LPM_CHANNELS,
   parameter int MF_FRAMES = lpm_pkg::LPM_MF_FRAMES
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst,
   // controller command side
   input  wire lpm_pkg::lpm_chan_cmd_t       chan_cmd [CHANNELS],
   input  wire logic                         trunk_loop_req [CHANNELS],
   input  wire logic                         trunk_loop_transp [CHANNELS],
   input  wire logic                         version_rd,
   input  wire logic                         multiframe_sync_marker,
   // line receiver side, asynchronous pins
   input  wire logic                         line_frame_tick,
   input  wire logic [CHANNELS-1:0]          line_viol,
   input  wire logic [CHANNELS-1:0]          line_frame_pos,
   // analog loop controls
   output lpm_pkg::lpm_loop_ctl_t            loop_ctl [CHANNELS],
   // status to controller
   output logic [7:0]                        device_command_register,
   output logic                              version_valid,
   output logic [CHANNELS-1:0]               code_violation_flag,
   output logic                              reset_done
);
   import lpm_pkg::*;

   // reset counter width, just enough to reach the least reset count
   localparam int       RST_CNT_W = $clog2(LPM_RST_MIN_CYC + 1);

   // synchroniser stages for line pins
   logic                tick_s1_q;            // frame tick, first flop
   logic                tick_s2_q;            // frame tick, second flop
   logic                tick_s3_q;            // frame tick, edge history
   logic [CHANNELS-1:0] viol_s1_q;            // violation pins, first flop
   logic [CHANNELS-1:0] viol_s2_q;            // violation pins, second flop
   logic [CHANNELS-1:0] viol_s3_q;            // violation pins, edge history
   logic [CHANNELS-1:0] fpos_s1_q;            // framing position, first flop
   logic [CHANNELS-1:0] fpos_s2_q;            // framing position, second flop
   logic                frame_pulse;          // one line frame elapsed
   logic [CHANNELS-1:0] viol_pulse;           // rising edge of violation pin
   logic [LPM_FRAME_W-1:0] frame_cnt_q;      // frames inside multiframe
   logic                mf_end;               // multiframe boundary
   logic [RST_CNT_W-1:0] rst_cnt_q;           // cycles since reset release
   logic                rdone_q;              // reset length reached
   logic [7:0]          ver_q;                // version answer register
   logic                ver_v_q;              // version answer valid

   // frame tick pin: two flops, then one stage that only feeds the edge detector
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
      end else begin
         tick_s1_q <= line_frame_tick;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
      end
   end

   // violation pins: two flops, then one stage that only feeds the edge detector
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         viol_s1_q <= '0;
         viol_s2_q <= '0;
         viol_s3_q <= '0;
      end else begin
         viol_s1_q <= line_viol;
         viol_s2_q <= viol_s1_q;
         viol_s3_q <= viol_s2_q;
      end
   end

   // framing position level: two flops, aligned with the violation pulse
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fpos_s1_q <= '0;
         fpos_s2_q <= '0;
      end else begin
         fpos_s1_q <= line_frame_pos;
         fpos_s2_q <= fpos_s1_q;
      end
   end

   // one-cycle pulses on rising edges of the synchronised pins
   assign frame_pulse = tick_s2_q & ~tick_s3_q;
   assign viol_pulse  = viol_s2_q & ~viol_s3_q;

   // multiframe counter, realigned by the controller marker
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_cnt_q <= '0;
      end else if (multiframe_sync_marker) begin
         frame_cnt_q <= '0; // [R13]
      end else if (frame_pulse) begin
         if (frame_cnt_q == LPM_FRAME_W'(MF_FRAMES - 1)) begin
            frame_cnt_q <= '0;
         end else begin
            frame_cnt_q <= frame_cnt_q + 1'b1;
         end
      end
   end

   // boundary on the last frame, or on a marker that finds the count out of step;
   // a marker just after a regular boundary only realigns, so that the
   // reporting interval is not cut short by a second boundary
   assign mf_end = (multiframe_sync_marker && frame_cnt_q != '0) ||
                   (frame_pulse && frame_cnt_q == LPM_FRAME_W'(MF_FRAMES - 1)); // [R12]

   // reset-length counter: counts clean cycles after release, then stops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_cnt_q <= '0;
      end else if (rst_cnt_q != RST_CNT_W'(LPM_RST_MIN_CYC)) begin
         rst_cnt_q <= rst_cnt_q + 1'b1;
      end
   end

   // reset-length status flop, set on the edge at which the count completes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdone_q <= 1'b0;
      end else if (rst_cnt_q == RST_CNT_W'(LPM_RST_MIN_CYC - 1)) begin
         rdone_q <= 1'b1; // [R1]
      end
   end

   assign reset_done = rdone_q;

   // version data: loaded on each read request, kept otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ver_q <= 8'h00;
      end else if (version_rd) begin
         ver_q <= LPM_VERSION; // [R4]
      end
   end

   // answer valid: stands one cycle for each request cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ver_v_q <= 1'b0;
      end else begin
         ver_v_q <= version_rd; // [R4]
      end
   end

   assign device_command_register = ver_q;
   assign version_valid           = ver_v_q;

   // per-channel loop decode and violation checker
   for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      lpm_loop_ctl_t ctl_q;       // registered loop controls
      lpm_loop_ctl_t ctl_d;       // next loop controls
      logic          two_wire;    // channel in two-wire mode

      assign two_wire = (chan_cmd[c].mode == LPM_MODE_TWO_WIRE);

      // trunk side loops come from its own state machine; others from bits
      always_comb begin
         ctl_d = LPM_LOOP_RST;
         case (chan_cmd[c].mode)
            LPM_MODE_TRUNK: begin
               ctl_d.loop_transp = trunk_loop_req[c] && trunk_loop_transp[c]; // [R6] [R5]
               ctl_d.loop_block  = trunk_loop_req[c] && !trunk_loop_transp[c]; // [R5]
               ctl_d.line_drive  = 1'b1;
            end
            LPM_MODE_TERM, LPM_MODE_TWO_WIRE: begin
               // loop bit closes loop, in two-wire mode only with line enable set; line enable decides transparency
               ctl_d.loop_transp = chan_cmd[c].loop_bit && chan_cmd[c].line_out_en; // [R8]
               ctl_d.loop_block  = chan_cmd[c].loop_bit && !chan_cmd[c].line_out_en &&
                                   !two_wire; // [R10]
               ctl_d.line_drive  = !chan_cmd[c].loop_bit || chan_cmd[c].line_out_en; // [R8]
            end
            default: begin
               ctl_d = LPM_LOOP_RST;
            end
         endcase
         ctl_d.loop_ext = chan_cmd[c].external_loop_bit; // [R9] [R5]
      end

      // registered loop controls
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            ctl_q <= LPM_LOOP_RST;
         end else begin
            ctl_q <= ctl_d;
         end
      end

      assign loop_ctl[c] = ctl_q;

      // violation check for this channel
      lpm_cv_chan u_cv (
         .clk                 (clk),
         .rst                 (rst),
         .two_wire            (two_wire),
         .viol                (viol_pulse[c]),
         .frame_pos           (fpos_s2_q[c]),
         .mf_end              (mf_end),
         .code_violation_flag (code_violation_flag[c])
      );
   end

endmodule : lpm_line_port

// ===== lpm_line_port_chk.sv
// lpm_line_port_chk: port-level timing checks of the line port
// assumes one clock domain; watches channel 0 as representative
`timescale 1ns/1ns
module lpm_line_port_chk #(
   parameter int CHANNELS = lpm_pkg::LPM_CHANNELS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // controller commands
   input wire lpm_pkg::lpm_chan_cmd_t chan_cmd [CHANNELS],
   input wire logic trunk_loop_req [CHANNELS],
   input wire logic trunk_loop_transp [CHANNELS],
   input wire logic version_rd,
   // observed outputs
   input wire lpm_pkg::lpm_loop_ctl_t loop_ctl [CHANNELS],
   input wire logic [7:0] device_command_register,
   input wire logic version_valid,
   input wire logic [CHANNELS-1:0] code_violation_flag
);
   import lpm_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   AST_EXT: assert property (
      !$past(rst) |-> loop_ctl[0].loop_ext == $past(chan_cmd[0].external_loop_bit))
      else $error("external loop not following command");
   AST_TRK: assert property (
      chan_cmd[0].mode == LPM_MODE_TRUNK && trunk_loop_req[0] |=>
      loop_ctl[0].loop_transp == $past(trunk_loop_transp[0]) && loop_ctl[0].line_drive)
      else $error("trunk loop wrong");
   AST_TRN: assert property (
      chan_cmd[0].mode inside {LPM_MODE_TERM, LPM_MODE_TWO_WIRE} && chan_cmd[0].loop_bit
      && chan_cmd[0].line_out_en |=> loop_ctl[0].loop_transp && loop_ctl[0].line_drive)
      else $error("transparent output missing");
   AST_TWB: assert property (
      chan_cmd[0].mode == LPM_MODE_TWO_WIRE && chan_cmd[0].loop_bit && !chan_cmd[0].line_out_en
      |=> !loop_ctl[0].loop_block && !loop_ctl[0].loop_transp)
      else $error("two-wire loop closed without enable");
   AST_TRB: assert property (
      chan_cmd[0].mode == LPM_MODE_TERM && chan_cmd[0].loop_bit && !chan_cmd[0].line_out_en
      |=> loop_ctl[0].loop_block && !loop_ctl[0].line_drive)
      else $error("blocked loop wrong");
   AST_OFF: assert property (
      chan_cmd[0].mode == 2'h3 |=> !loop_ctl[0].loop_transp && !loop_ctl[0].loop_block)
      else $error("loop closed in unused mode");
   AST_VER: assert property (
      version_rd |=> version_valid && device_command_register == LPM_VERSION)
      else $error("version answer wrong");
   AST_VNO: assert property (
      !version_rd |=> !version_valid ##0 $stable(device_command_register))
      else $error("version answer without request");
   // main scenarios reached
   cover property (version_rd ##1 version_rd);
   cover property (code_violation_flag[0]);
   cover property (chan_cmd[0].mode == LPM_MODE_TWO_WIRE && chan_cmd[0].loop_bit);
endmodule : lpm_line_port_chk
bind lpm_line_port lpm_line_port_chk #(.CHANNELS(CHANNELS)) u_chk (.clk(clk), .rst(rst),
   .chan_cmd(chan_cmd), .trunk_loop_req(trunk_loop_req), .trunk_loop_transp(trunk_loop_transp),
   .version_rd(version_rd), .loop_ctl(loop_ctl), .version_valid(version_valid),
   .device_command_register(device_command_register), .code_violation_flag(code_violation_flag));

// ===== lpm_ctrl_model.sv
// lpm_ctrl_model: far-side frame ticks and multiframe marker
// assumes one clock; a line frame spans two link frames of LINK_CYC cycles
`timescale 1ns/1ns
module lpm_ctrl_model #(
   parameter int LINK_CYC = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // frame timing
   output logic line_frame_tick,
   output logic multiframe_sync_marker
);
   import lpm_pkg::*;
   int cnt_q; // cycle within one marker period
   // count cycles, wrap every marker period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 0;
      end else begin
         cnt_q <= (cnt_q == LPM_MF_LINK * LINK_CYC - 1) ? 0 : cnt_q + 1;
      end
   end
   assign line_frame_tick = (cnt_q % (2 * LINK_CYC)) >= LINK_CYC;
   assign multiframe_sync_marker = (cnt_q == 1);
endmodule : lpm_ctrl_model

// ===== lpm_line_port_tb.sv
// lpm_line_port_tb: self-checking bench of the line port
// assumes lpm_ctrl_model provides frame timing; inputs change at falling edge
`timescale 1ns/1ns
module lpm_line_port_tb;
   import lpm_pkg::*;
   localparam int CH = LPM_CHANNELS;
   localparam int LINK = 4;                          // cycles per link frame in the model
   localparam int MF_CYC = LPM_MF_FRAMES * 2 * LINK; // cycles per multiframe
   logic clk, rst, version_rd, marker, tick, valid, rdone;
   lpm_chan_cmd_t cmd [CH];
   logic req [CH];
   logic tr [CH];
   lpm_loop_ctl_t ctl [CH];
   logic [CH-1:0] viol, fpos, flag;
   logic [7:0] dcr;
   int error_cnt = 0;
   int n_compared = 0;
   int seed = 32'h9c9e;
   int i, c, k;
   lpm_line_port #(.MF_FRAMES(LPM_MF_FRAMES)) u_dut (.clk(clk), .rst(rst), .chan_cmd(cmd),
      .trunk_loop_req(req), .trunk_loop_transp(tr), .version_rd(version_rd),
      .multiframe_sync_marker(marker), .line_frame_tick(tick), .line_viol(viol),
      .line_frame_pos(fpos), .loop_ctl(ctl), .device_command_register(dcr),
      .version_valid(valid), .code_violation_flag(flag), .reset_done(rdone));
   lpm_ctrl_model #(.LINK_CYC(LINK)) u_ctrl (.clk(clk), .rst(rst), .line_frame_tick(tick),
      .multiframe_sync_marker(marker));
   // expected loop controls of one channel
   function automatic lpm_loop_ctl_t exp_loop(lpm_chan_cmd_t m, logic q, logic t);
      logic x;
      x = m.external_loop_bit;
      case (m.mode)
         LPM_MODE_TRUNK: return '{q & t, q & ~t, x, 1'b1};
         LPM_MODE_TERM, LPM_MODE_TWO_WIRE: return '{m.loop_bit & m.line_out_en,
            m.loop_bit & ~m.line_out_en & (m.mode != LPM_MODE_TWO_WIRE), x,
            ~m.loop_bit | m.line_out_en};
         default: return '{1'b0, 1'b0, x, 1'b0};
      endcase
   endfunction : exp_loop
   // compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // bounded wait for flag of channel 0
   task automatic wait_flag(input logic lvl);
      for (int k = 0; k < 200 && flag[0] !== lvl; k++) @(negedge clk);
      chk({7'h0, flag[0]}, {7'h0, lvl});
   endtask : wait_flag
   task automatic print_verdict();
      $display("compared=%0d errors=%0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : print_verdict
   initial begin
      clk = 0;
      forever #2 clk = ~clk;
   end
   initial begin
      #80000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      rst = 1;
      version_rd = 0;
      viol = '0;
      fpos = '0;
      for (c = 0; c < CH; c++) begin
         cmd[c] = '0;
         req[c] = 0;
         tr[c] = 0;
      end
      repeat (20) @(negedge clk);
      chk(dcr, 8'h00);
      rst = 0;
      repeat (260) @(negedge clk);
      chk({7'h0, rdone}, 8'h01);
      // version read comes first after release, back to back
      version_rd = 1;
      @(negedge clk);
      chk({7'h0, valid}, 8'h01);
      @(negedge clk);
      version_rd = 0;
      chk(dcr, LPM_VERSION);
      @(negedge clk);
      chk({7'h0, valid}, 8'h00);
      // random loop commands, every mode first
      for (i = 0; i < 40; i++) begin
         for (c = 0; c < CH; c++) begin
            cmd[c] = lpm_chan_cmd_t'(5'($random(seed)));
            if (i < 4) cmd[c].mode = lpm_mode_t'(2'(i));
            req[c] = 1'($random(seed));
            tr[c] = 1'($random(seed));
         end
         @(negedge clk);
         for (c = 0; c < CH; c++) chk(8'(ctl[c]), 8'(exp_loop(cmd[c], req[c], tr[c])));
      end
      // violations: four-wire, two-wire at framing bit, two-wire in payload
      cmd[0].mode = LPM_MODE_TERM;
      cmd[1].mode = LPM_MODE_TWO_WIRE;
      cmd[2].mode = LPM_MODE_TWO_WIRE;
      fpos = 8'h02;
      viol = 8'h07;
      repeat (3) @(negedge clk);
      viol = '0;
      fpos = '0;
      wait_flag(1'b1);
      @(negedge clk);
      chk(8'(flag), 8'h05);
      // flag must stand one full multiframe before it clears
      for (k = 1; k < 250 && flag[0] === 1'b1; k++) @(negedge clk);
      chk(8'(k), 8'(MF_CYC));
      wait_flag(1'b0);
      // reset in mid-run clears outputs
      rst = 1;
      @(negedge clk);
      chk(dcr | 8'(flag) | 8'(ctl[0]), 8'h00);
      rst = 0;
      repeat (2) @(negedge clk);
      print_verdict();
   end
endmodule : lpm_line_port_tb
